// *** hw/ssl_top.sv ***
// serial latch bank, dividers, pump control and status output
`timescale 1ns/1ns
module ssl_top (
  input  wire logic       clock_in,
  input  wire logic       reset_in,
  input  wire logic       serial_clk_in,      // serial clock pin
  input  wire logic       serial_data_in,     // serial data pin
  input  wire logic       load_strobe_in,     // load strobe pin
  input  wire logic       chip_enable_in,     // high to run
  input  wire logic       ref_clk_in,         // reference input
  input  wire logic       fb_clk_in,          // feedback input
  output logic            status_out_pin_out, // multiplexed status
  output logic            pump_up_out,
  output logic            pump_down_out,
  output logic            pump_oe_n_out,      // low while pump drives
  output logic [2:0]      pump_current_out,
  output logic            lock_od_out,        // open-drain level
  output logic            lock_od_oe_n_out,   // low while pulling down
  output logic            digital_lock_out
);
  import ssl_pkg::*;

  ssl_pd_if pd_bus ();

  // modulus from the two select bits
  function automatic logic [6:0] modulus(input logic [1:0] sel);
    modulus = 7'h08 << sel;
  endfunction

  function automatic logic [FBDIV_W-1:0] fb_ratio(input logic [23:0] fbw,
                                                  input logic [23:0] fnw);
    logic [FBDIV_W-1:0] prod;
    prod = FBDIV_W'(fbw[MAIN_LSB +: MAIN_W]) * FBDIV_W'(modulus(fnw[MODULUS_LSB +: 2]));
    fb_ratio = prod + FBDIV_W'(fbw[SWALLOW_LSB +: SWALLOW_W]);
  endfunction

  // pin synchronisers, stage one read only by stage two
  logic [5:0] pin_s1_q;
  logic [5:0] pin_s2_q;
  logic [5:0] pin_prev_q;   // for edge detection
  logic       sclk_rise;
  logic       strobe_rise;
  logic       ref_rise;
  logic       fb_rise;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pin_s1_q   <= 6'h00;
      pin_s2_q   <= 6'h00;
      pin_prev_q <= 6'h00;
    end else begin
      pin_s1_q   <= {fb_clk_in, ref_clk_in, chip_enable_in,
                     load_strobe_in, serial_data_in, serial_clk_in};
      pin_s2_q   <= pin_s1_q;
      pin_prev_q <= pin_s2_q;
    end
  end

  assign sclk_rise   = pin_s2_q[0] && !pin_prev_q[0];
  assign strobe_rise = pin_s2_q[2] && !pin_prev_q[2];
  assign ref_rise    = pin_s2_q[4] && !pin_prev_q[4];
  assign fb_rise     = pin_s2_q[5] && !pin_prev_q[5];

  // serial shift register
  logic [WORD_W-1:0] shift_q;
  always_ff @(posedge clock_in) begin
    if (reset_in)
      shift_q <= LATCH_RESET;
    else if (sclk_rise)
      shift_q <= {shift_q[WORD_W-2:0], pin_s2_q[1]};
  end

  // latches; init also clears the counters for one cycle
  logic [WORD_W-1:0] ref_latch_q;
  logic [WORD_W-1:0] fb_latch_q;
  logic [WORD_W-1:0] func_latch_q;
  logic              init_clr_q;

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      ref_latch_q  <= LATCH_RESET;
      fb_latch_q   <= LATCH_RESET;
      func_latch_q <= LATCH_RESET;
      init_clr_q   <= 1'b0;
    end else begin
      init_clr_q <= 1'b0;
      if (strobe_rise) begin
        unique case (shift_q[SEL_LSB +: 2])
          SEL_REF:  ref_latch_q  <= shift_q;  // fields kept in place
          SEL_FB:   fb_latch_q   <= shift_q;
          SEL_FUNC: func_latch_q <= shift_q;
          SEL_INIT: begin
            func_latch_q <= shift_q;
            init_clr_q   <= 1'b1;
          end
        endcase
      end
    end
  end

  // power state from enable pin and power-down bit
  logic powered;
  logic cnt_clear;
  assign powered   = pin_s2_q[3] && !func_latch_q[PD_A_BIT];
  assign cnt_clear = !powered || func_latch_q[CNT_RESET_BIT] || init_clr_q;

  // reference divider
  logic [REFDIV_W-1:0] ref_cnt_q;
  logic                ref_tick_q;
  logic [REFDIV_W-1:0] ref_ratio;
  assign ref_ratio = ref_latch_q[REFDIV_LSB +: REFDIV_W];

  always_ff @(posedge clock_in) begin
    if (reset_in || cnt_clear) begin
      ref_cnt_q  <= '0;
      ref_tick_q <= 1'b0;
    end else begin
      ref_tick_q <= 1'b0;
      // one tick per ratio edges, zero acts as one
      if (ref_rise) begin
        if (ref_cnt_q + 14'h0001 >= ref_ratio) begin
          ref_cnt_q  <= '0;
          ref_tick_q <= 1'b1;
        end else begin
          ref_cnt_q <= ref_cnt_q + 14'h0001;
        end
      end
    end
  end

  // feedback divider; main count below 3 is not guarded
  logic [FBDIV_W-1:0] fb_cnt_q;
  logic               fb_tick_q;
  logic [FBDIV_W-1:0] fb_limit;
  assign fb_limit = fb_ratio(fb_latch_q, func_latch_q);

  always_ff @(posedge clock_in) begin
    if (reset_in || cnt_clear) begin
      fb_cnt_q  <= '0;
      fb_tick_q <= 1'b0;
    end else begin
      fb_tick_q <= 1'b0;
      if (fb_rise) begin
        if (fb_cnt_q + 20'h00001 >= fb_limit) begin
          fb_cnt_q  <= '0;
          fb_tick_q <= 1'b1;
        end else begin
          fb_cnt_q <= fb_cnt_q + 20'h00001;
        end
      end
    end
  end

  // detector compares the two divided edges
  assign pd_bus.ref_tick = ref_tick_q;
  assign pd_bus.fb_tick  = fb_tick_q;
  assign pd_bus.precise  = ref_latch_q[PRECISION_BIT];
  assign pd_bus.run      = !cnt_clear;

  ssl_lock_detect u_lock (
    .clock_in (clock_in),
    .reset_in (reset_in),
    .pd_io    (pd_bus.detector)
  );

  // antibacklash overlap after each closed cycle
  logic [2:0] backlash_q;
  always_ff @(posedge clock_in) begin
    if (reset_in)
      backlash_q <= 3'h0;
    else if (pd_bus.cycle_done)
      backlash_q <= {1'b0, ref_latch_q[BACKLASH_LSB +: 2]} + 3'h1;
    else if (backlash_q != 3'h0)
      backlash_q <= backlash_q - 3'h1;
  end

  // pump drive; polarity low swaps the directions
  logic up_raw;
  logic down_raw;
  logic mismatch;
  assign mismatch = pd_bus.ref_lead || pd_bus.fb_lead;
  assign up_raw   = pd_bus.ref_lead || (backlash_q != 3'h0);
  assign down_raw = pd_bus.fb_lead || (backlash_q != 3'h0);

  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      pump_up_out   <= 1'b0;
      pump_down_out <= 1'b0;
      pump_oe_n_out <= 1'b1;
    end else begin
      pump_up_out   <= func_latch_q[POLARITY_BIT] ? up_raw : down_raw;
      pump_down_out <= func_latch_q[POLARITY_BIT] ? down_raw : up_raw;
      pump_oe_n_out <= !powered || func_latch_q[TRISTATE_BIT];
    end
  end

  // pump current: second setting when fast acquire and gain bit set
  always_ff @(posedge clock_in) begin
    if (reset_in)
      pump_current_out <= 3'h0;
    else if (func_latch_q[FAST_EN_BIT] && fb_latch_q[GAIN_BIT])
      pump_current_out <= func_latch_q[CUR_B_LSB +: 3];
    else
      pump_current_out <= func_latch_q[CUR_A_LSB +: 3];
  end

  // analog lock and digital lock pins
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      lock_od_out      <= 1'b0;
      lock_od_oe_n_out <= 1'b1;
      digital_lock_out <= 1'b0;
    end else begin
      // pull low only while edges disagree
      lock_od_out      <= 1'b0;
      lock_od_oe_n_out <= !mismatch;
      digital_lock_out <= pd_bus.lock;
    end
  end

  // status multiplexer
  always_ff @(posedge clock_in) begin
    if (reset_in) begin
      status_out_pin_out <= 1'b0;
    end else begin
      unique case (func_latch_q[OUTSEL_LSB +: 3])
        OUT_DLOCK:    status_out_pin_out <= pd_bus.lock;
        OUT_FB_TICK:  status_out_pin_out <= fb_tick_q;
        OUT_HIGH:     status_out_pin_out <= 1'b1;
        OUT_REF_TICK: status_out_pin_out <= ref_tick_q;
        OUT_ALOCK:    status_out_pin_out <= !mismatch;
        OUT_SDATA:    status_out_pin_out <= pin_s2_q[1];
        default:      status_out_pin_out <= 1'b0;
      endcase
    end
  end

  a_shift_capture: assert property (@(posedge clock_in) disable iff (reset_in)
    sclk_rise |=> shift_q[0] == $past(pin_s2_q[1])
      && shift_q[WORD_W-1:1] == $past(shift_q[WORD_W-2:0]))
    else $error("serial bit not captured");
  a_latch_select: assert property (@(posedge clock_in) disable iff (reset_in)
    strobe_rise && shift_q[1:0] == SEL_FB |=> fb_latch_q == $past(shift_q) && $stable(ref_latch_q))
    else $error("feedback word went to wrong latch");
  a_latch_load: assert property (@(posedge clock_in) disable iff (reset_in)
    !strobe_rise |=> $stable(ref_latch_q) && $stable(fb_latch_q) && $stable(func_latch_q))
    else $error("latch changed without strobe");
  a_ref_divide: assert property (@(posedge clock_in) disable iff (reset_in)
    ref_tick_q |-> $past(ref_rise) && ref_cnt_q == '0)
    else $error("reference tick without edge");
  a_outsel_dlock: assert property (@(posedge clock_in) disable iff (reset_in)
    func_latch_q[OUTSEL_LSB +: 3] == OUT_DLOCK && $stable(func_latch_q)
      |=> status_out_pin_out == $past(pd_bus.lock))
    else $error("status output not showing lock");
  a_pump_off: assert property (@(posedge clock_in) disable iff (reset_in)
    !pin_s2_q[3] |=> pump_oe_n_out ##1 !pd_bus.lock)
    else $error("pump or lock active while disabled");
  a_backlash_len: assert property (@(posedge clock_in) disable iff (reset_in)
    pd_bus.cycle_done
      |=> backlash_q == {1'b0, $past(ref_latch_q[BACKLASH_LSB +: 2])} + 3'h1)
    else $error("backlash overlap length wrong");
  a_alock_pulse: assert property (@(posedge clock_in) disable iff (reset_in)
    mismatch |=> !lock_od_oe_n_out && !lock_od_out)
    else $error("analog lock not pulled low on error");
endmodule

// *** hw/ssl_pkg.sv ***
// constants and types shared by the synthesizer control section
package ssl_pkg;
  // serial word and latch select
  localparam int          WORD_W        = 24;
  localparam int          SEL_LSB       = 0;
  localparam logic [1:0]  SEL_REF       = 2'h0;
  localparam logic [1:0]  SEL_FB        = 2'h1;
  localparam logic [1:0]  SEL_FUNC      = 2'h2;
  localparam logic [1:0]  SEL_INIT      = 2'h3;
  localparam logic [23:0] LATCH_RESET   = 24'h000000;
  // reference divider latch fields
  localparam int          REFDIV_LSB    = 2;
  localparam int          REFDIV_W      = 14;
  localparam int          BACKLASH_LSB  = 16;
  localparam int          TEST_LSB      = 18;
  localparam int          PRECISION_BIT = 20;
  // feedback divider latch fields
  localparam int          SWALLOW_LSB   = 2;
  localparam int          SWALLOW_W     = 6;
  localparam int          MAIN_LSB      = 8;
  localparam int          MAIN_W        = 13;
  localparam int          GAIN_BIT      = 21;
  localparam int          FBDIV_W       = 20;
  // function and initialization latch fields
  localparam int          CNT_RESET_BIT = 2;
  localparam int          PD_A_BIT      = 3;
  localparam int          OUTSEL_LSB    = 4;
  localparam int          POLARITY_BIT  = 7;
  localparam int          TRISTATE_BIT  = 8;
  localparam int          FAST_EN_BIT   = 9;
  localparam int          FAST_MODE_BIT = 10;
  localparam int          TIMEOUT_LSB   = 11;
  localparam int          CUR_A_LSB     = 15;
  localparam int          CUR_B_LSB     = 18;
  localparam int          PD_B_BIT      = 21;
  localparam int          MODULUS_LSB   = 22;
  // status output select codes
  localparam logic [2:0]  OUT_LOW       = 3'h0;
  localparam logic [2:0]  OUT_DLOCK     = 3'h1;
  localparam logic [2:0]  OUT_FB_TICK   = 3'h2;
  localparam logic [2:0]  OUT_HIGH      = 3'h3;
  localparam logic [2:0]  OUT_REF_TICK  = 3'h4;
  localparam logic [2:0]  OUT_ALOCK     = 3'h5;
  localparam logic [2:0]  OUT_SDATA     = 3'h6;
  // timing
  localparam int          CLK_NS        = 40;
  localparam int          LOCK_SET_NS   = 15;
  localparam int          LOCK_DROP_NS  = 25;
  localparam int          SET_CYC       = (LOCK_SET_NS + CLK_NS - 1) / CLK_NS;
  localparam int          DROP_RAW      = LOCK_DROP_NS / CLK_NS;
  localparam int          DROP_CYC      = (DROP_RAW < 1) ? 1 : DROP_RAW;
  localparam logic [3:0]  SET_ERR       = 4'(SET_CYC);
  localparam logic [3:0]  DROP_ERR      = 4'(DROP_CYC);
  localparam logic [2:0]  GOOD_COARSE   = 3'h3;
  localparam logic [2:0]  GOOD_FINE     = 3'h5;
  // phase detector states
  typedef enum logic [2:0] {
    PD_IDLE     = 3'b001,
    PD_WAIT_FB  = 3'b010,
    PD_WAIT_REF = 3'b100
  } ssl_pd_state_type;
endpackage

// *** hw/ssl_pd_if.sv ***
// signals between the divider section and the lock detector
`timescale 1ns/1ns
interface ssl_pd_if;
  logic ref_tick;   // divided reference edge
  logic fb_tick;    // divided feedback edge
  logic precise;    // five-cycle lock qualification
  logic run;        // detector powered and counting
  logic lock;       // digital lock level
  logic ref_lead;   // reference edge waiting for feedback
  logic fb_lead;    // feedback edge waiting for reference
  logic cycle_done; // one detector cycle closed
  modport source (output ref_tick, fb_tick, precise, run,
                  input lock, ref_lead, fb_lead, cycle_done);
  modport detector (input ref_tick, fb_tick, precise, run,
                    output lock, ref_lead, fb_lead, cycle_done);
endinterface

// *** hw/ssl_lock_detect.sv ***
// phase detector and digital lock detector
`timescale 1ns/1ns
module ssl_lock_detect (
  input  wire logic clock_in,
  input  wire logic reset_in,
  ssl_pd_if.detector pd_io
);
  import ssl_pkg::*;

  ssl_pd_state_type state_q;  // which edge is outstanding
  ssl_pd_state_type state_d;
  logic [3:0]       err_q;    // phase error in clock cycles
  logic [2:0]       good_q;   // consecutive good cycles
  logic             lock_q;
  logic             done_q;
  logic             done;     // cycle closes now
  logic [3:0]       err_end;  // error of the closing cycle
  logic [2:0]       need;

  // edge pairing; a repeat edge while waiting is ignored
  always_comb begin
    state_d = state_q;
    done    = 1'b0;
    err_end = err_q;
    unique case (state_q)
      PD_IDLE: begin
        if (pd_io.ref_tick && pd_io.fb_tick) begin
          done    = 1'b1;
          err_end = 4'h0;
        end else if (pd_io.ref_tick) begin
          state_d = PD_WAIT_FB;
        end else if (pd_io.fb_tick) begin
          state_d = PD_WAIT_REF;
        end
      end
      PD_WAIT_FB: begin
        if (pd_io.fb_tick) begin
          done    = 1'b1;
          state_d = PD_IDLE;
        end
      end
      PD_WAIT_REF: begin
        if (pd_io.ref_tick) begin
          done    = 1'b1;
          state_d = PD_IDLE;
        end
      end
      default: state_d = PD_IDLE;
    endcase
  end

  // state and error count, set back to idle and to one when not running
  always_ff @(posedge clock_in) begin
    if (reset_in || !pd_io.run) begin
      state_q <= PD_IDLE;
      err_q   <= 4'h1;
      done_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      done_q  <= done;
      // saturate so a lost edge reads as large error
      if (state_d == PD_IDLE)
        err_q <= 4'h1;
      else if (err_q != 4'hf)
        err_q <= err_q + 4'h1;
    end
  end

  assign need = pd_io.precise ? GOOD_FINE : GOOD_COARSE;

  // lock qualification on each closed cycle
  always_ff @(posedge clock_in) begin
    if (reset_in || !pd_io.run) begin
      good_q <= 3'h0;
      lock_q <= 1'b0;
    end else if (done) begin
      if (err_end >= DROP_ERR) begin
        good_q <= 3'h0;
        lock_q <= 1'b0;
      end else if (err_end < SET_ERR) begin
        if (good_q != 3'h7)
          good_q <= good_q + 3'h1;
        if (good_q + 3'h1 >= need)
          lock_q <= 1'b1;
      end else begin
        good_q <= 3'h0;
      end
    end
  end

  assign pd_io.lock       = lock_q;
  assign pd_io.ref_lead   = (state_q == PD_WAIT_FB);
  assign pd_io.fb_lead    = (state_q == PD_WAIT_REF);
  assign pd_io.cycle_done = done_q;

  a_lock_coarse: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(lock_q) && !$past(pd_io.precise) |-> $past(good_q) == 3'h2)
    else $error("coarse lock set without three good cycles");
  a_lock_fine: assert property (@(posedge clock_in) disable iff (reset_in)
    $rose(lock_q) && $past(pd_io.precise) |-> $past(good_q) == 3'h4)
    else $error("fine lock set without five good cycles");
  a_lock_drop: assert property (@(posedge clock_in) disable iff (reset_in)
    lock_q && done && err_end >= DROP_ERR && pd_io.run |=> !lock_q)
    else $error("lock kept after large phase error");
  a_lock_hold: assert property (@(posedge clock_in) disable iff (reset_in)
    lock_q && !done && pd_io.run |=> lock_q)
    else $error("lock dropped without a bad cycle");
endmodule

// *** testbench/ssl_host_model.sv ***
// host controller model driving the three-wire serial programming link
`timescale 1ns/1ns
module ssl_host_model (
  input  wire logic clock_in,
  output logic      serial_clk_out,
  output logic      serial_data_out,
  output logic      load_strobe_out
);
  // serial clock stands still low between frames
  initial begin
    serial_clk_out  = 1'b0;
    serial_data_out = 1'b0;
    load_strobe_out = 1'b0;
  end

  // one word, every phase at least two clock cycles so the pin synchroniser sees it
  task automatic send_word(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      @(negedge clock_in) serial_data_out = w[i];
      repeat (2) @(negedge clock_in);
      serial_clk_out = 1'b1;
      repeat (2) @(negedge clock_in);
      serial_clk_out = 1'b0;
    end
    // released data line has no pull, so show the inverse of the last bit
    serial_data_out = ~w[0];
    repeat (2) @(negedge clock_in);
    load_strobe_out = 1'b1;
    repeat (2) @(negedge clock_in);
    load_strobe_out = 1'b0;
  endtask
endmodule

// *** testbench/testbench.sv ***
// self-checking bench for the synthesizer control section
`timescale 1ns/1ns
module testbench;
  import ssl_pkg::*;
  // status select codes tried and the level each must give while unlocked
  localparam logic [14:0] SEL_TAB = {3'h7, OUT_SDATA, OUT_HIGH, OUT_DLOCK, OUT_LOW};
  localparam logic [4:0] SEL_EXP     = 5'h0c;
  logic        clock_in    = 1'b0;
  logic        reset_in    = 1'b1;
  logic        chip_enable = 1'b1;          // device run pin
  logic        skew        = 1'b1;          // feedback lags reference one cycle
  logic        ref_clk     = 1'b0;          // reference input, period four cycles
  logic        ref_d       = 1'b0;          // reference delayed one cycle
  logic [1:0]  phase       = 2'h0;
  logic        fb_clk;
  logic        sclk;
  logic        sdata;
  logic        strobe;
  logic        status;
  logic        pump_up;
  logic        pump_dn;
  logic        pump_oe_n;
  logic        lock_od;
  logic        lock_oe_n;
  logic        dlock;
  logic [2:0]  pump_cur;
  logic [31:0] rnd         = 32'h6a846495;  // lfsr state, fixed seed
  int          n_fail      = 0;
  int          check_count = 0;
  int          cyc         = 0;

  ssl_host_model host (.clock_in(clock_in), .serial_clk_out(sclk),
                       .serial_data_out(sdata), .load_strobe_out(strobe));
  ssl_top dut (
    .clock_in(clock_in), .reset_in(reset_in), .serial_clk_in(sclk),
    .serial_data_in(sdata), .load_strobe_in(strobe), .chip_enable_in(chip_enable),
    .ref_clk_in(ref_clk), .fb_clk_in(fb_clk), .status_out_pin_out(status),
    .pump_up_out(pump_up), .pump_down_out(pump_dn), .pump_oe_n_out(pump_oe_n),
    .pump_current_out(pump_cur), .lock_od_out(lock_od), .lock_od_oe_n_out(lock_oe_n),
    .digital_lock_out(dlock));

  initial begin
    forever #20 clock_in = ~clock_in;
  end

  // reference and feedback inputs, both slow enough for the synchronisers
  always @(negedge clock_in) begin
    phase   <= phase + 2'h1;
    ref_clk <= (phase < 2'h2);
    ref_d   <= ref_clk;
  end
  assign fb_clk = skew ? ref_d : ref_clk;

  // hang guard, well above the roughly eleven and a half thousand cycles expected
  always @(posedge clock_in) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail = n_fail + 1;
      end_of_test();
    end
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // cycles between reference ticks: main count three, four cycles per edge
  function automatic int tick_period(input int m, input int s);
    return 4 * (3 * (8 << m) + s);
  endfunction

  task automatic check_bit(input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic check_num(input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // settle time covers the strobe path plus the output register
  task automatic send(input logic [23:0] w);
    host.send_word(w);
    repeat (8) @(negedge clock_in);
  endtask

  // function or initialization word, bits 9 to 21 random
  task automatic send_fn(input logic [1:0] sel, input logic [1:0] m,
                         input logic [2:0] outsel, input logic crst, input logic tri_st);
    rnd = lfsr(rnd);
    send({m, rnd[12:0], tri_st, 1'b1, outsel, 1'b0, crst, sel});
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin : main
    int          k;
    int          n;
    int          t_first;
    int          per;
    int          w;
    logic        prev;
    logic        seen_low;
    logic        fine_lock;
    logic        gain;
    logic [1:0]  code;
    logic [5:0]  s;
    logic [13:0] ratio;
    repeat (10) @(negedge clock_in);
    check_bit(1'b1, pump_oe_n);
    check_bit(1'b1, lock_oe_n);
    check_bit(1'b0, dlock);
    reset_in = 1'b0;
    repeat (3) @(negedge clock_in);
    $display("test reset done");
    // only the function and initialization selects may move the status field
    send_fn(SEL_FUNC, 2'h0, OUT_HIGH, 1'b0, 1'b0);
    check_bit(1'b1, status);
    send({4'h0, rnd[1:0], 2'h1, 14'h0020, SEL_REF});
    check_bit(1'b1, status);
    send({3'h0, 13'h0003, 6'h00, SEL_FB});
    check_bit(1'b1, status);
    send_fn(SEL_INIT, 2'h0, OUT_LOW, 1'b0, 1'b0);
    check_bit(1'b0, status);
    for (int i = 0; i < 5; i++) begin
      send_fn(SEL_FUNC, 2'h0, SEL_TAB[3*i +: 3], 1'b0, 1'b0);
      check_bit(SEL_EXP[i], status);
    end
    $display("test status select done");
    // one lock case per prescaler modulus, both precisions
    for (int m = 0; m < 4; m++) begin
      rnd = lfsr(rnd);
      s = {3'h0, rnd[2:0]};
      code = (rnd[4:3] == 2'h0) ? 2'h1 : rnd[4:3];
      fine_lock = m[0];
      ratio = 14'(tick_period(m, int'(s)) / 4);
      send_fn(SEL_FUNC, 2'(m), OUT_REF_TICK, 1'b1, 1'b0);
      // host avoids the minimum backlash code
      send({3'h0, fine_lock, rnd[6:5], code, ratio, SEL_REF});
      gain = rnd[7];
      send({2'h0, gain, 13'h0003, s, SEL_FB});
      skew = 1'b0;
      send_fn(SEL_FUNC, 2'(m), OUT_REF_TICK, 1'b0, 1'b0);
      // second current setting only with fast acquire and gain bit both set
      check_num({29'h0, (rnd[0] && gain) ? rnd[11:9] : rnd[8:6]}, {29'h0, pump_cur});
      n = 0;
      t_first = 0;
      per = 0;
      k = 0;
      prev = status;
      while (dlock !== 1'b1 && k < 6000) begin
        @(negedge clock_in);
        k++;
        if (status === 1'b1 && prev === 1'b0) begin
          n++;
          if (n == 1) t_first = k;
          if (n == 2) per = k - t_first;
        end
        prev = status;
      end
      check_num(fine_lock ? 5 : 3, n);
      check_num(tick_period(m, int'(s)), per);
      check_bit(1'b1, dlock);
      check_bit(1'b0, pump_oe_n);
      k = 0;
      while (!(pump_up === 1'b1 && pump_dn === 1'b1) && k < 2000) begin
        @(negedge clock_in);
        k++;
      end
      w = 0;
      while (pump_up === 1'b1 && pump_dn === 1'b1 && w < 10) begin
        @(negedge clock_in);
        w++;
      end
      check_num(int'(code) + 1, w);
      // one-cycle phase error must drop the lock within one detector cycle
      skew = 1'b1;
      k = 0;
      seen_low = 1'b0;
      while (dlock !== 1'b0 && k < 2000) begin
        @(negedge clock_in);
        k++;
        if (lock_oe_n === 1'b0) seen_low = 1'b1;
      end
      check_bit(1'b0, dlock);
      check_bit(1'b1, logic'(k <= tick_period(m, int'(s)) + 8));
      check_bit(1'b1, seen_low);
      check_bit(1'b0, lock_od);
      $display("test lock case %0d done", m);
    end
    chip_enable = 1'b0;
    repeat (8) @(negedge clock_in);
    check_bit(1'b1, pump_oe_n);
    chip_enable = 1'b1;
    send_fn(SEL_FUNC, 2'h0, OUT_LOW, 1'b0, 1'b1);
    check_bit(1'b1, pump_oe_n);
    $display("test pump enable done");
    end_of_test();
  end
endmodule
